/* File: pkg/xsb_alu_defs.vh */
// Offsets, field positions, encodings and reset values of the extended shift and borrow datapath.
`ifndef XSB_ALU_DEFS_VH
`define XSB_ALU_DEFS_VH

// Register byte offsets.
`define XSB_OFF_OPERAND 8'h00
`define XSB_OFF_INSN 8'h04
`define XSB_OFF_STATUS 8'h08
`define XSB_OFF_RESULT 8'h0C
`define XSB_OFF_INFO 8'h10

// Instruction word fields.
`define XSB_INSN_OP_LSB 0
`define XSB_INSN_OP_MSB 2
`define XSB_INSN_SIZE_LSB 4
`define XSB_INSN_SIZE_MSB 5
`define XSB_INSN_CNT_LSB 8
`define XSB_INSN_CNT_MSB 9
`define XSB_INSN_MODE_LSB 12
`define XSB_INSN_MODE_MSB 13
`define XSB_INSN_GO_BIT 15

// Operation codes.
`define XSB_OP_MULTI_ROT 3'h0
`define XSB_OP_SINGLE_ROT 3'h1
`define XSB_OP_MULTI_USHIFT 3'h2
`define XSB_OP_SINGLE_USHIFT 3'h3
`define XSB_OP_BORROW_SUB 3'h4

// Operand sizes.
`define XSB_SIZE_BYTE 2'h0
`define XSB_SIZE_WORD 2'h1
`define XSB_SIZE_AWORD 2'h2

// Destination modes.
`define XSB_MODE_REG 2'h0
`define XSB_MODE_MEM 2'h1
`define XSB_MODE_IMM 2'h2

// Status register bit positions.
`define XSB_SR_C 0
`define XSB_SR_Z 1
`define XSB_SR_N 2
`define XSB_SR_GIE 3
`define XSB_SR_HALT 4
`define XSB_SR_OSC 5
`define XSB_SR_V 8

// Info register bit positions.
`define XSB_INFO_BUSY 0
`define XSB_INFO_ILLEGAL 1

// Reset values.
`define XSB_RST_OPERAND 20'h0_0000
`define XSB_RST_INSN 16'h0000
`define XSB_RST_STATUS 9'h000
`define XSB_RST_RESULT 20'h0_0000

// All-ones addend for each size.
`define XSB_ONES_BYTE 20'h0_00FF
`define XSB_ONES_WORD 20'h0_FFFF
`define XSB_ONES_AWORD 20'hF_FFFF

`endif

/* File: rtl/xsb_shift_unit.v */
// Combinational right shifter and rotator through carry for byte, word and address-word operands.
`timescale 1ns/10ps
`include "xsb_alu_defs.vh"

module xsb_shift_unit (
	// Operand and carry in.
	input wire [19:0] operand,
	input wire carry_in,
	// Operation selection.
	input wire [1:0] size,
	input wire [1:0] count_m1,
	input wire unsigned_fill,
	// Shifted result and carry out.
	output reg [19:0] result,
	output reg carry_out
);

	// One step right: fill enters the top bit of the chosen width, upper bits cleared.
	function [19:0] xsb_step;
		input [19:0] val;
		input fill;
		input [1:0] sz;
		begin
			case (sz)
				`XSB_SIZE_BYTE: xsb_step = {12'h000, fill, val[7:1]};
				`XSB_SIZE_WORD: xsb_step = {4'h0, fill, val[15:1]};
				default: xsb_step = {fill, val[19:1]};
			endcase
		end
	endfunction

	integer i;
	reg [19:0] work;
	reg cy;

	// Repeat the single step n times; the carry ends up holding operand bit n-1.
	always @* begin
		work = 20'h0_0000;
		cy = carry_in;
		case (size)
			`XSB_SIZE_BYTE: work = {12'h000, operand[7:0]};
			`XSB_SIZE_WORD: work = {4'h0, operand[15:0]};
			default: work = operand;
		endcase
		for (i = 0; i < 4; i = i + 1) begin
			if (i <= count_m1) begin
				work = xsb_step(work, unsigned_fill ? 1'b0 : cy, size);
				cy = (i == 0) ? operand[0] : operand[i];
			end
		end
		result = work;
		carry_out = cy;
	end

endmodule

/* File: rtl/xsb_alu.v */
// Extended right shift, rotate through carry and borrow subtract datapath with its register port.
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/10ps
`include "xsb_alu_defs.vh"

// What this block does
// - Single rotate supports 20, 16, 8-bit sizes.
// - Multi rotate: carry in MSB, LSB out, n=1..4.
// - Multi rotate word form clears bits 19:16.
// - Multi ops carry takes operand bit n-1.
// - Negative copies bit 19, 15 or 7.
// - Shifts: zero on zero result, overflow cleared.
// - Multi ops single word, count in opcode.
// - Register single rotate clears upper bits.
// - Memory single rotate: any mode but immediate.
// - Single rotate loads carry from LSB.
// - Multi unsigned shift fills zeros, n=1..4.
// - Single unsigned shift register only, zero fill.
// - Oscillator, halt, interrupt mode bits untouched.
// - Borrow subtract adds carry plus all ones.
// - Borrow subtract sets C, V, N, Z.
// - Borrow is the inverse of carry.

module xsb_alu (
	// Clock and synchronous active-low reset.
	input wire sys_clk,
	input wire rst_n,
	// Register port.
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	// Live state for the surrounding core.
	output wire [19:0] dst_value,
	output wire [8:0] status_value,
	output wire busy
);

	// Software-visible state.
	// Status bits 6 and 7 are plain storage and are neither set nor cleared by any operation.
	reg [19:0] operand_q;
	reg [19:0] operand_d;
	reg [15:0] insn_q;
	reg [15:0] insn_d;
	reg [8:0] status_q;
	reg [8:0] status_d;
	reg [19:0] result_q;
	reg [19:0] result_d;
	reg illegal_q;
	reg illegal_d;

	// Execution stage: one pending instruction word.
	// A start written in the commit cycle simply loads the next word, so starts may come back to back.
	reg exec_q;
	reg exec_d;
	reg [15:0] exec_insn_q;
	reg [15:0] exec_insn_d;

	// Decoded fields of the pending instruction.
	// They come from the latched word, so a later write to the instruction register cannot disturb them.
	wire [2:0] ex_op;
	wire [1:0] ex_size;
	wire [1:0] ex_cnt;
	wire [1:0] ex_mode;
	wire ex_multi;
	wire ex_single;
	wire ex_unsigned;
	wire ex_legal;

	// Datapath signals.
	wire [19:0] sh_result;
	wire sh_carry;
	reg [19:0] alu_result;
	reg alu_carry;
	reg alu_ovf;
	reg alu_neg;
	reg alu_zero;
	reg [20:0] sub_sum;
	reg [19:0] ones;
	reg [19:0] dst_masked;

	// Bus decode.
	wire wr_operand;
	wire wr_insn;
	wire wr_status;
	wire wr_info;
	wire go;

	// Writes decode on the full byte address, so nearby unmapped addresses are ignored.
	// The result and the busy bit have no write decode and cannot be changed by software.
	assign wr_operand = reg_wr && (reg_addr == `XSB_OFF_OPERAND);
	assign wr_insn = reg_wr && (reg_addr == `XSB_OFF_INSN);
	assign wr_status = reg_wr && (reg_addr == `XSB_OFF_STATUS);
	assign wr_info = reg_wr && (reg_addr == `XSB_OFF_INFO);
	// One instruction word starts the operation; no extension word is awaited.
	assign go = wr_insn && reg_wdata[`XSB_INSN_GO_BIT];

	// Field extraction; the shift count sits in the opcode itself.
	assign ex_op = exec_insn_q[`XSB_INSN_OP_MSB:`XSB_INSN_OP_LSB];
	assign ex_size = exec_insn_q[`XSB_INSN_SIZE_MSB:`XSB_INSN_SIZE_LSB];
	assign ex_cnt = exec_insn_q[`XSB_INSN_CNT_MSB:`XSB_INSN_CNT_LSB];
	assign ex_mode = exec_insn_q[`XSB_INSN_MODE_MSB:`XSB_INSN_MODE_LSB];
	assign ex_multi = (ex_op == `XSB_OP_MULTI_ROT) || (ex_op == `XSB_OP_MULTI_USHIFT);
	assign ex_single = (ex_op == `XSB_OP_SINGLE_ROT) || (ex_op == `XSB_OP_SINGLE_USHIFT);
	assign ex_unsigned = (ex_op == `XSB_OP_MULTI_USHIFT) || (ex_op == `XSB_OP_SINGLE_USHIFT);

	// Legality of op, size and destination mode combinations.
	// Size code 3 and destination code 3 are unused encodings and are always refused.
	reg legal_r;
	always @* begin
		legal_r = 1'b0;
		case (ex_op)
			// Multi forms are register-only, address-word or word.
			`XSB_OP_MULTI_ROT, `XSB_OP_MULTI_USHIFT: begin
				legal_r = (ex_mode == `XSB_MODE_REG) && (ex_size != `XSB_SIZE_BYTE) &&
					(ex_size != 2'h3);
			end
			// Single rotate: all three sizes, any destination but immediate.
			`XSB_OP_SINGLE_ROT: begin
				legal_r = (ex_size != 2'h3) && (ex_mode != `XSB_MODE_IMM) && (ex_mode != 2'h3);
			end
			// Single unsigned shift exists only for a register destination.
			`XSB_OP_SINGLE_USHIFT: begin
				legal_r = (ex_size != 2'h3) && (ex_mode == `XSB_MODE_REG);
			end
			// Borrow subtract writes a register or memory destination.
			`XSB_OP_BORROW_SUB: begin
				legal_r = (ex_size != 2'h3) && (ex_mode != `XSB_MODE_IMM) && (ex_mode != 2'h3);
			end
			default: begin
				legal_r = 1'b0;
			end
		endcase
	end
	assign ex_legal = legal_r;

	// Shared shifter; single forms always move by one position.
	// The carry input is the stored flag, so a rotate picks up the carry left by the previous instruction.
	xsb_shift_unit u_shift (
		.operand(operand_q),
		.carry_in(status_q[`XSB_SR_C]),
		.size(ex_size),
		.count_m1(ex_single ? 2'h0 : ex_cnt),
		.unsigned_fill(ex_unsigned),
		.result(sh_result),
		.carry_out(sh_carry)
	);

	// Result and flag computation for the pending operation.
	always @* begin
		ones = `XSB_ONES_AWORD;
		dst_masked = operand_q;
		sub_sum = 21'h00_0000;
		alu_result = 20'h0_0000;
		alu_carry = 1'b0;
		alu_ovf = 1'b0;
		alu_neg = 1'b0;
		case (ex_size)
			`XSB_SIZE_BYTE: begin
				ones = `XSB_ONES_BYTE;
				dst_masked = {12'h000, operand_q[7:0]};
			end
			`XSB_SIZE_WORD: begin
				ones = `XSB_ONES_WORD;
				dst_masked = {4'h0, operand_q[15:0]};
			end
			default: begin
				ones = `XSB_ONES_AWORD;
				dst_masked = operand_q;
			end
		endcase
		// The addend is minus one, so overflow only happens when the most negative value loses one.
		// That is the case where the destination sign is set and the result sign is clear.
		if (ex_op == `XSB_OP_BORROW_SUB) begin
			// Adding all ones plus carry: carry 1 means no borrow, carry 0 takes one away.
			sub_sum = {1'b0, dst_masked} + {1'b0, ones} + {20'h0_0000, status_q[`XSB_SR_C]};
			case (ex_size)
				`XSB_SIZE_BYTE: begin
					alu_result = {12'h000, sub_sum[7:0]};
					alu_carry = sub_sum[8];
					alu_ovf = dst_masked[7] && !sub_sum[7];
				end
				`XSB_SIZE_WORD: begin
					alu_result = {4'h0, sub_sum[15:0]};
					alu_carry = sub_sum[16];
					alu_ovf = dst_masked[15] && !sub_sum[15];
				end
				default: begin
					alu_result = sub_sum[19:0];
					alu_carry = sub_sum[20];
					alu_ovf = dst_masked[19] && !sub_sum[19];
				end
			endcase
		end else begin
			// Shifter output already has the bits above the operand width cleared.
			alu_result = sh_result;
			alu_carry = sh_carry;
			alu_ovf = 1'b0;
		end
		case (ex_size)
			`XSB_SIZE_BYTE: alu_neg = alu_result[7];
			`XSB_SIZE_WORD: alu_neg = alu_result[15];
			default: alu_neg = alu_result[19];
		endcase
		alu_zero = (alu_result == 20'h0_0000);
	end

	// A refused instruction never commits, so the destination and the flags keep their values.
	// The sticky illegal flag is the only trace that it leaves behind.
	wire commit;
	assign commit = exec_q && ex_legal;

	// Next-state logic for the register file and execution stage.
	always @* begin
		operand_d = operand_q;
		insn_d = insn_q;
		status_d = status_q;
		result_d = result_q;
		illegal_d = illegal_q;
		exec_d = go;
		exec_insn_d = exec_insn_q;
		if (wr_operand) begin
			operand_d = reg_wdata[19:0];
		end
		if (wr_insn) begin
			insn_d = {1'b0, reg_wdata[14:0]};
		end
		if (go) begin
			exec_insn_d = reg_wdata[15:0];
		end
		if (wr_status) begin
			status_d = reg_wdata[8:0];
		end
		// Writing one clears the illegal flag; a new illegal event below still wins.
		if (wr_info && reg_wdata[`XSB_INFO_ILLEGAL]) begin
			illegal_d = 1'b0;
		end
		if (exec_q && !ex_legal) begin
			illegal_d = 1'b1;
		end
		// Destination, result and the four arithmetic flags land on the same edge.
		// The commit overrides a software write to the destination made in the same cycle.
		if (commit) begin
			operand_d = alu_result;
			result_d = alu_result;
			status_d[`XSB_SR_C] = alu_carry;
			status_d[`XSB_SR_Z] = alu_zero;
			status_d[`XSB_SR_N] = alu_neg;
			status_d[`XSB_SR_V] = alu_ovf;
			// Mode bits keep the value they had, including one written this cycle.
			status_d[`XSB_SR_GIE] = wr_status ? reg_wdata[`XSB_SR_GIE] : status_q[`XSB_SR_GIE];
			status_d[`XSB_SR_HALT] = wr_status ? reg_wdata[`XSB_SR_HALT] : status_q[`XSB_SR_HALT];
			status_d[`XSB_SR_OSC] = wr_status ? reg_wdata[`XSB_SR_OSC] : status_q[`XSB_SR_OSC];
		end
	end

	// State registers.
	// The reset is synchronous, so every register takes its reset value on a clock edge only.
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			operand_q <= `XSB_RST_OPERAND;
			insn_q <= `XSB_RST_INSN;
			status_q <= `XSB_RST_STATUS;
			result_q <= `XSB_RST_RESULT;
			illegal_q <= 1'b0;
			exec_q <= 1'b0;
			exec_insn_q <= `XSB_RST_INSN;
		end else begin
			operand_q <= operand_d;
			insn_q <= insn_d;
			status_q <= status_d;
			result_q <= result_d;
			illegal_q <= illegal_d;
			exec_q <= exec_d;
			exec_insn_q <= exec_insn_d;
		end
	end

	// Returning zero outside the valid cycle keeps stale data off the bus.
	// Read data for the cycle after a read strobe, zero otherwise and for unmapped addresses.
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			case (reg_addr)
				`XSB_OFF_OPERAND: reg_rdata <= {12'h000, operand_q};
				`XSB_OFF_INSN: reg_rdata <= {16'h0000, insn_q};
				`XSB_OFF_STATUS: reg_rdata <= {23'h00_0000, status_q};
				`XSB_OFF_RESULT: reg_rdata <= {12'h000, result_q};
				`XSB_OFF_INFO: reg_rdata <= {30'h0000_0000, illegal_q, exec_q};
				default: reg_rdata <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	// Live views for the core.
	// They come straight from flip-flops, so the core sees no combinational path from the register port.
	assign dst_value = operand_q;
	assign status_value = status_q;
	assign busy = exec_q;

endmodule

/* File: verif/xsb_alu_chk.sv */
// Port-level checks of the shift and borrow datapath.
`timescale 1ns/10ps
module xsb_alu_chk (
	// Clock and reset.
	input wire sys_clk,
	input wire rst_n,
	// Register port.
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [31:0] reg_rdata,
	// Live state.
	input wire [19:0] dst_value,
	input wire [8:0] status_value,
	input wire busy
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	reg [15:0] ins_q;
	// Decode of the instruction that is executing.
	wire go = reg_wr && reg_addr == 8'h04 && reg_wdata[15];
	wire [2:0] op = ins_q[2:0];
	wire [1:0] sz = ins_q[5:4];
	wire [1:0] md = ins_q[13:12];
	wire bad = sz == 2'h3 || op > 3'h4 || md > 2'h1 || (md != 2'h0 && op != 3'h1 && op != 3'h4)
		|| (sz == 2'h0 && !op[0] && op != 3'h4);
	wire top = sz == 2'h0 ? dst_value[7] : (sz == 2'h1 ? dst_value[15] : dst_value[19]);
	wire cbit = op[0] ? dst_value[0] : dst_value[ins_q[9:8]];
	wire sw_st = reg_wr && reg_addr == 8'h08;
	wire sw_op = reg_wr && reg_addr == 8'h00;
	// Keeps the last started instruction word.
	always @(posedge sys_clk) begin
		if (go) begin
			ins_q <= reg_wdata[15:0];
		end
	end
	property p_busy_go; go |=> busy; endproperty
	a_busy_go: assert property (p_busy_go) else $error("no busy after start");
	property p_busy_one; busy && !go |=> !busy; endproperty
	a_busy_one: assert property (p_busy_one) else $error("busy too long");
	property p_mode; busy && !sw_st |=> $stable(status_value[5:3]); endproperty
	a_mode: assert property (p_mode) else $error("mode bits changed");
	property p_v0; busy && !bad && op != 3'h4 |=> !status_value[8]; endproperty
	a_v0: assert property (p_v0) else $error("overflow not cleared");
	property p_zero; busy && !bad |=> status_value[1] == (dst_value == 20'h0_0000); endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");
	property p_neg; busy && !bad && !go |=> status_value[2] == top; endproperty
	a_neg: assert property (p_neg) else $error("negative flag wrong");
	property p_upper; busy && !bad && !go && sz != 2'h2 |=> dst_value[19:16] == 4'h0
		&& (sz != 2'h0 || dst_value[15:8] == 8'h00); endproperty
	a_upper: assert property (p_upper) else $error("upper bits kept");
	property p_carry; busy && !bad && op != 3'h4 |=> status_value[0] == $past(cbit); endproperty
	a_carry: assert property (p_carry) else $error("carry bit wrong");
	property p_hold; busy && bad && !sw_op |=> $stable(dst_value); endproperty
	a_hold: assert property (p_hold) else $error("refused op changed state");
endmodule

/* File: verif/test_xsb_alu.sv */
// Self-checking bench for the shift and borrow datapath.
`timescale 1ns/10ps
`include "xsb_alu_defs.vh"
module test_xsb_alu;
	reg sys_clk = 1'b0;
	reg rst_n = 1'b0;
	reg [7:0] reg_addr = 8'h00;
	reg [31:0] reg_wdata = 32'h0000_0000;
	reg reg_wr = 1'b0;
	reg reg_rd = 1'b0;
	wire [31:0] reg_rdata;
	wire [19:0] dst_value;
	wire [8:0] status_value;
	wire busy;
	integer miscompares = 0;
	integer num_checks = 0;
	integer cyc = 0;
	integer k;
	reg [95:0] bad_tab = {16'h0000, 16'h1010, 16'h2011, 16'h1013, 16'h0030, 16'h0005};
	xsb_alu dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .dst_value(dst_value), .status_value(status_value), .busy(busy));
	// Clock of 100 ns period.
	initial begin
		forever #50 sys_clk = ~sys_clk;
	end
	// Prints the counts and the verdict, then stops.
	task final_report;
		begin
			$display("checks %0d mismatches %0d", num_checks, miscompares);
			if (miscompares == 0 && num_checks > 0) begin
				$display("SIMULATION PASSED");
			end else begin
				$display("SIMULATION FAILED");
			end
			$finish;
		end
	endtask
	// One write strobe cycle; the strobe stays up until the next task.
	task wr(input [7:0] a, input [31:0] d);
		begin
			reg_wr <= 1'b1;
			reg_rd <= 1'b0;
			reg_addr <= a;
			reg_wdata <= d;
			@(posedge sys_clk);
		end
	endtask
	// Read; the data stand only in the cycle after the strobe and are taken at its falling edge.
	task rd(input [7:0] a, input [31:0] e);
		begin
			reg_wr <= 1'b0;
			reg_rd <= 1'b1;
			reg_addr <= a;
			@(posedge sys_clk);
			reg_rd <= 1'b0;
			@(negedge sys_clk);
			num_checks = num_checks + 1;
			if (reg_rdata !== e) begin
				miscompares = miscompares + 1;
				$display("[FAIL] %0t addr %h got %h exp %h", $time, a, reg_rdata, e);
			end
			@(posedge sys_clk);
		end
	endtask
	// Loads operand and status, starts one instruction, checks the committed state.
	task op(input [19:0] v, input [8:0] s, input [15:0] i, input [19:0] ev, input [8:0] es);
		begin
			wr(`XSB_OFF_OPERAND, {12'h000, v});
			wr(`XSB_OFF_STATUS, {23'h00_0000, s});
			wr(`XSB_OFF_INSN, {16'h0000, i | 16'h8000});
			reg_wr <= 1'b0;
			@(negedge sys_clk);
			num_checks = num_checks + 1;
			if (busy !== 1'b1) begin
				miscompares = miscompares + 1;
				$display("[FAIL] %0t busy not raised after start", $time);
			end
			@(posedge sys_clk);
			rd(`XSB_OFF_OPERAND, {12'h000, ev});
			rd(`XSB_OFF_STATUS, {23'h00_0000, es});
		end
	endtask
	// Main sequence.
	initial begin
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		for (k = 0; k < 6; k = k + 1) begin
			rd(k == 5 ? 8'h20 : 8'(k * 4), 32'h0000_0000);
		end
		op(20'h0_0008, 9'h139, 16'h0220, 20'h2_0001, 9'h038);
		op(20'hF_0009, 9'h000, 16'h0310, 20'h0_2000, 9'h001);
		op(20'hA_BC01, 9'h001, 16'h0301, 20'h0_0080, 9'h005);
		op(20'h0_0001, 9'h001, 16'h0021, 20'h8_0000, 9'h005);
		op(20'h0_0000, 9'h000, 16'h1011, 20'h0_0000, 9'h002);
		op(20'hF_FFF0, 9'h001, 16'h0322, 20'h0_FFFF, 9'h000);
		op(20'h1_8001, 9'h000, 16'h0012, 20'h0_4000, 9'h001);
		op(20'hF_FF81, 9'h001, 16'h0003, 20'h0_0040, 9'h001);
		op(20'h0_0000, 9'h000, 16'h0004, 20'h0_00FF, 9'h004);
		op(20'h0_8000, 9'h000, 16'h0014, 20'h0_7FFF, 9'h101);
		op(20'h0_0000, 9'h001, 16'h0024, 20'h0_0000, 9'h003);
		op(20'h0_0080, 9'h001, 16'h0004, 20'h0_0080, 9'h005);
		// Refused combinations leave state alone and raise the sticky flag.
		for (k = 0; k < 6; k = k + 1) begin
			op(20'h0_1234, 9'h13F, bad_tab[k * 16 +: 16], 20'h0_1234, 9'h13F);
			rd(`XSB_OFF_INFO, 32'h0000_0002);
			wr(`XSB_OFF_INFO, 32'h0000_0002);
			rd(`XSB_OFF_INFO, 32'h0000_0000);
		end
		// Second start in the commit cycle works on the committed value.
		wr(`XSB_OFF_OPERAND, 32'h0000_0004);
		wr(`XSB_OFF_STATUS, 32'h0000_0000);
		wr(`XSB_OFF_INSN, 32'h0000_8013);
		wr(`XSB_OFF_INSN, 32'h0000_8013);
		rd(`XSB_OFF_INFO, 32'h0000_0001);
		rd(`XSB_OFF_OPERAND, 32'h0000_0001);
		rd(`XSB_OFF_RESULT, 32'h0000_0001);
		rd(`XSB_OFF_STATUS, 32'h0000_0000);
		rd(`XSB_OFF_INSN, 32'h0000_0013);
		final_report;
	end
	// Cuts a hang short.
	always @(posedge sys_clk) begin
		cyc = cyc + 1;
		if (cyc > 2000) begin
			miscompares = miscompares + 1;
			$display("[FAIL] %0t timeout", $time);
			final_report;
		end
	end
endmodule
bind xsb_alu xsb_alu_chk chk (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dst_value(dst_value),
	.status_value(status_value), .busy(busy));
